/* File: hdl/wdt_consts.svh */
// Constant values for the windowed watchdog timer
`ifndef WDT_CONSTS_SVH
`define WDT_CONSTS_SVH

// ---------------------------------------------------------------
// Configuration word one field positions
// ---------------------------------------------------------------
`define CFG_PRESCALE_BIT      4
`define CFG_POSTSCALE_MSB     3
`define CFG_POSTSCALE_LSB     0
`define CFG_HW_ENABLE_POS     7
`define CFG_WINDOW_DIS_POS    6

// ---------------------------------------------------------------
// Reset control register bit positions
// ---------------------------------------------------------------
`define RESET_CONTROL_REG_SW_ENABLE_POS    5
`define RESET_CONTROL_REG_TIMEOUT_POS      4
`define RESET_CONTROL_REG_SLEEP_POS        3
`define RESET_CONTROL_REG_IDLE_POS         2

// ---------------------------------------------------------------
// Prescaler widths and window codes
// ---------------------------------------------------------------
`define PRESCALE_SHORT_BITS   5'h05
`define PRESCALE_LONG_BITS    5'h07
`define WIN_SEL_25            2'h3
`define WIN_SEL_37            2'h2
`define WIN_SEL_50            2'h1
`define WIN_SEL_75            2'h0

// ---------------------------------------------------------------
// Reset values
// ---------------------------------------------------------------
`define ERASED_CFG_WORD       8'hFF
`define RST_STATUS_FLAG       1'h0
`define RST_SW_ENABLE         1'h0

`endif

/* File: hdl/wdt_pkg.sv */
// Types shared by the windowed watchdog timer files
package wdt_pkg;

	// Power state of the core as seen by the watchdog
	typedef enum logic [1:0] {
		CORE_RUN,
		CORE_SLEEP,
		CORE_IDLE
	} core_state_type;

endpackage

/* File: hdl/wdt_window_check.sv */
// Period end and disallowed window decode for the watchdog counter
`timescale 1ns/1ps

`include "wdt_consts.svh"

module wdt_window_check #(
	parameter int CNT_W = 22
) (
	input  wire logic [CNT_W-1:0] count,
	input  wire logic             prescale_long,
	input  wire logic [3:0]       postscale_sel,
	input  wire logic [1:0]       window_sel,
	input  wire logic             window_bits_present,
	output logic                  at_period_end,
	output logic                  in_disallowed
);

	// ---------------------------------------------------------------
	// Decode helpers
	// ---------------------------------------------------------------

	// Full period in oscillator edges: 2^(prescale bits + postscale)
	function automatic logic [CNT_W:0] period_of(input logic lng,
		input logic [3:0] post);
		logic [4:0] sh;
		sh = (lng ? `PRESCALE_LONG_BITS : `PRESCALE_SHORT_BITS)
			+ {1'h0, post};
		period_of = (CNT_W+1)'(1) << sh;
	endfunction

	wire [CNT_W:0] period  = period_of(prescale_long, postscale_sel);
	wire [CNT_W:0] half    = period >> 1;
	wire [CNT_W:0] quarter = period >> 2;
	wire [CNT_W:0] eighth  = period >> 3;
	// Bits absent behave as the quarter window
	wire [1:0]     sel     = window_bits_present ? window_sel
		: `WIN_SEL_25;

	// Disallowed part runs from the last clear up to this count
	wire [CNT_W:0] limit =
		(sel == `WIN_SEL_25) ? half + quarter :
		(sel == `WIN_SEL_37) ? half + eighth  :
		(sel == `WIN_SEL_50) ? half           :
		                       quarter;

	// Allowed window is the final part of the period [R16] [R17]
	assign at_period_end = ({1'h0, count}
		== period - {{CNT_W{1'h0}}, 1'h1});
	assign in_disallowed = ({1'h0, count} < limit);

endmodule

/* File: hdl/windowed_watchdog_timer.sv */
// Windowed watchdog timer: counter, enables, window and status flags
//
// Overview of operation
// [R1] Enabled counter increments, overflow signals time-out
// [R2] Counter advances on low-power oscillator edges
// [R3] Time-out while running forces device reset
// [R4] Time-out in sleep or idle wakes core
// [R5] Software clears watchdog before overflow
// [R6] Every watchdog reset or wake sets time-out flag
// [R7] Wake also sets sleep or idle flag
// [R8] Hardware enable bit forces watchdog on
// [R9] Erased configuration leaves hardware enable set
// [R10] Otherwise software enable bit enables watchdog
// [R11] Software enable cleared on every device reset
// [R12] Window disable bit zero selects windowed mode
// [R13] Windowed mode needs hardware enable set
// [R14] Software clears only inside allowed window
// [R15] Early clear in windowed mode resets device
// [R16] Window select gives 25, 37.5, 50, 75 percent
// [R17] Allowed window is final part of period
// [R18] Counter cleared on resets, save, enable, switch, clear
// [R19] Prescaler divides by 32 or 128
// [R20] Postscaler divides by 1 up to 32768
// [R21] Clear and save strobes captured into oscillator domain; only the clear is held to the next edge, save restarts the count at once
`timescale 1ns/1ps

`include "wdt_consts.svh"

module windowed_watchdog_timer #(
	parameter int                  CNT_W    = 22,
	parameter logic [7:0]          CFG_INIT = `ERASED_CFG_WORD
) (
	input  wire logic              clk,
	input  wire logic              arst_n,
	input  wire logic              clk_en,
	input  wire logic              low_power_rc_osc,
	input  wire logic              cfg_load,
	input  wire logic [7:0]        cfg_word_in,
	input  wire logic [1:0]        window_size_select,
	input  wire logic              window_bits_present,
	input  wire logic              watchdog_clear_instr,
	input  wire logic              power_save_instr,
	input  wire logic              power_save_idle,
	input  wire logic              other_wake,
	input  wire logic              device_reset_in,
	input  wire logic              clock_switch_done,
	input  wire logic              sw_enable_wr,
	input  wire logic              sw_enable_wdata,
	input  wire logic              status_clear,
	output logic [7:0]             config_word_one,
	output logic                   sw_watchdog_enable,
	output logic                   timeout_status_flag,
	output logic                   sleep_status_flag,
	output logic                   idle_status_flag,
	output logic                   watchdog_active,
	output logic                   device_reset_req,
	output logic                   core_wake,
	output logic [CNT_W-1:0]       watchdog_counter
);

	// ---------------------------------------------------------------
	// State
	// ---------------------------------------------------------------
	wdt_pkg::core_state_type core_state_ff;   // Core power state
	logic                    osc_prev_ff;     // Oscillator last level
	logic                    clr_pend_ff;     // Clear waiting for edge
	logic                    en_ff;           // Enable, registered

	// ---------------------------------------------------------------
	// Configuration decode
	// ---------------------------------------------------------------
	wire hw_en      = config_word_one[`CFG_HW_ENABLE_POS];
	wire win_dis    = config_word_one[`CFG_WINDOW_DIS_POS];
	wire pre_long   = config_word_one[`CFG_PRESCALE_BIT];    // [R19]
	wire [3:0] post = config_word_one[`CFG_POSTSCALE_MSB:
		`CFG_POSTSCALE_LSB];                                 // [R20]

	// Either enable source turns the counter on
	wire enabled    = hw_en | sw_watchdog_enable;            // [R8] [R10]
	// Window only with the hardware enable and window bit low
	wire windowed   = hw_en & ~win_dis;                      // [R12] [R13]
	// Software enable going from off to on
	wire sw_rise    = sw_enable_wr & sw_enable_wdata
		& ~sw_watchdog_enable;

	// Counter advances only on a rising oscillator edge
	wire osc_tick   = low_power_rc_osc & ~osc_prev_ff;       // [R2]
	wire running    = (core_state_ff == wdt_pkg::CORE_RUN);

	wire at_end;
	wire early;

	// Period end and window position of the current count
	wdt_window_check #(
		.CNT_W               (CNT_W)
	) u_window (
		.count               (watchdog_counter),
		.prescale_long       (pre_long),
		.postscale_sel       (post),
		.window_sel          (window_size_select),
		.window_bits_present (window_bits_present),
		.at_period_end       (at_end),
		.in_disallowed       (early)
	);

	// Overflow on the edge that completes the period
	wire timeout    = enabled & osc_tick & at_end;           // [R1]
	// Clear landing in the disallowed part of the period
	wire bad_clear  = enabled & windowed & running
		& watchdog_clear_instr & early;                      // [R15]
	wire good_clear = watchdog_clear_instr & ~bad_clear;
	// Time-out while running, or early clear, resets the device
	wire rst_event  = (timeout & running) | bad_clear;       // [R3]
	wire wake_event = timeout & ~running;                    // [R4]

	// Any of these restart counter, prescaler and postscaler
	wire restart    = device_reset_in | power_save_instr | sw_rise
		| clock_switch_done | clr_pend_ff | timeout
		| bad_clear;                                         // [R18]

	// ---------------------------------------------------------------
	// Configuration word held from load, erased value at reset
	// ---------------------------------------------------------------
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			config_word_one <= CFG_INIT;                     // [R9]
		end else if (clk_en && cfg_load) begin
			config_word_one <= cfg_word_in;
		end
	end

	// ---------------------------------------------------------------
	// Strobe capture: a permitted clear is held until next edge
	// ---------------------------------------------------------------
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			osc_prev_ff <= 1'h0;
			clr_pend_ff <= 1'h0;
		end else if (clk_en) begin
			osc_prev_ff <= low_power_rc_osc;
			if (good_clear) begin
				clr_pend_ff <= 1'h1;                         // [R21]
			end else if (osc_tick) begin
				clr_pend_ff <= 1'h0;
			end
		end
	end

	// ---------------------------------------------------------------
	// Watchdog counter
	// ---------------------------------------------------------------
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			watchdog_counter <= '0;
		end else if (clk_en) begin
			if (!enabled || (restart && !osc_tick)) begin
				watchdog_counter <= '0;
			end else if (osc_tick) begin
				// Restart pending at the edge lands the count at zero
				watchdog_counter <= restart ? '0
					: watchdog_counter
					+ {{(CNT_W-1){1'h0}}, 1'h1};             // [R1] [R5]
			end
		end
	end

	// ---------------------------------------------------------------
	// Software enable, cleared by any device reset
	// ---------------------------------------------------------------
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			sw_watchdog_enable <= `RST_SW_ENABLE;
		end else if (clk_en) begin
			if (device_reset_in || rst_event) begin
				sw_watchdog_enable <= 1'h0;                  // [R11]
			end else if (sw_enable_wr) begin
				sw_watchdog_enable <= sw_enable_wdata;
			end
		end
	end

	// ---------------------------------------------------------------
	// Core power state tracking
	// ---------------------------------------------------------------
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			core_state_ff <= wdt_pkg::CORE_RUN;
		end else if (clk_en) begin
			case (core_state_ff)
				wdt_pkg::CORE_RUN: begin
					if (device_reset_in || rst_event) begin
						core_state_ff <= wdt_pkg::CORE_RUN;
					end else if (power_save_instr) begin
						core_state_ff <= power_save_idle
							? wdt_pkg::CORE_IDLE
							: wdt_pkg::CORE_SLEEP;
					end
				end
				default: begin
					// Any wake returns the core to running
					if (device_reset_in || wake_event || other_wake) begin
						core_state_ff <= wdt_pkg::CORE_RUN;
					end
				end
			endcase
		end
	end

	// ---------------------------------------------------------------
	// Status flags: a set in the clearing cycle wins
	// ---------------------------------------------------------------
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			timeout_status_flag <= `RST_STATUS_FLAG;
			sleep_status_flag   <= `RST_STATUS_FLAG;
			idle_status_flag    <= `RST_STATUS_FLAG;
		end else if (clk_en) begin
			timeout_status_flag <= (rst_event | wake_event)
				| (timeout_status_flag & ~status_clear);     // [R6]
			sleep_status_flag   <= (wake_event
				& (core_state_ff == wdt_pkg::CORE_SLEEP))
				| (sleep_status_flag & ~status_clear);       // [R7]
			idle_status_flag    <= (wake_event
				& (core_state_ff == wdt_pkg::CORE_IDLE))
				| (idle_status_flag & ~status_clear);        // [R7]
		end
	end

	// ---------------------------------------------------------------
	// Registered event outputs
	// ---------------------------------------------------------------
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			device_reset_req <= 1'h0;
			core_wake        <= 1'h0;
			en_ff            <= 1'h0;
		end else if (clk_en) begin
			device_reset_req <= rst_event;                   // [R3] [R15]
			core_wake        <= wake_event;                  // [R4]
			en_ff            <= enabled;
		end
	end

	assign watchdog_active = en_ff;

endmodule

/* File: bench/windowed_watchdog_timer_assertions.sv */
// Concurrent checks on the watchdog timer top-level ports
`timescale 1ns/1ps
module windowed_watchdog_timer_assertions #(
	parameter int CNT_W = 22
) (
	input wire logic             clk,
	input wire logic             arst_n,
	input wire logic             clk_en,
	input wire logic             low_power_rc_osc,
	input wire logic             cfg_load,
	input wire logic [7:0]       cfg_word_in,
	input wire logic [1:0]       window_size_select,
	input wire logic             window_bits_present,
	input wire logic             watchdog_clear_instr,
	input wire logic             power_save_instr,
	input wire logic             power_save_idle,
	input wire logic             other_wake,
	input wire logic             device_reset_in,
	input wire logic             clock_switch_done,
	input wire logic             sw_enable_wr,
	input wire logic             sw_enable_wdata,
	input wire logic             status_clear,
	input wire logic [7:0]       config_word_one,
	input wire logic             sw_watchdog_enable,
	input wire logic             timeout_status_flag,
	input wire logic             sleep_status_flag,
	input wire logic             idle_status_flag,
	input wire logic             watchdog_active,
	input wire logic             device_reset_req,
	input wire logic             core_wake,
	input wire logic [CNT_W-1:0] watchdog_counter
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!arst_n);
	// Either watchdog event: reset request or wake
	sequence s_event;
		device_reset_req || core_wake;
	endsequence
	// Reset of the device by a synchronous reset request
	sequence s_dev_reset;
		clk_en && device_reset_in && !sw_enable_wr;
	endsequence
	AST_FLAG_ON_EVENT: assert property (s_event |-> timeout_status_flag)
		else $error("time-out flag missing on watchdog event");
	AST_WAKE_NO_RESET: assert property (core_wake |-> !device_reset_req)
		else $error("wake and reset request together");
	AST_WAKE_STATE_FLAG: assert property (core_wake |->
		sleep_status_flag || idle_status_flag)
		else $error("wake without sleep or idle flag");
	AST_RESET_PULSE: assert property (clk_en && device_reset_req |=>
		!device_reset_req)
		else $error("reset request longer than one cycle");
	AST_WAKE_PULSE: assert property (clk_en && core_wake |=>
		!core_wake)
		else $error("wake longer than one cycle");
	AST_DEV_RESET: assert property (s_dev_reset |=>
		!sw_watchdog_enable && watchdog_counter == '0)
		else $error("device reset left enable or count");
	AST_ACTIVE_FOLLOWS: assert property (clk_en && $past(arst_n) |=>
		watchdog_active == $past(config_word_one[7] | sw_watchdog_enable))
		else $error("active flag does not follow enables");
	AST_HELD_IDLE: assert property ((!watchdog_active) [*2] |->
		watchdog_counter == '0)
		else $error("counter moves while disabled");
	AST_COUNT_STEP: assert property (
		watchdog_counter != $past(watchdog_counter) |->
		watchdog_counter == '0 ||
		watchdog_counter == CNT_W'($past(watchdog_counter) + 1))
		else $error("counter jumped");
	// Status flag holds until a clear with no new event
	AST_FLAG_STICKY: assert property (clk_en && !status_clear &&
		timeout_status_flag |=> timeout_status_flag)
		else $error("time-out flag dropped without a clear");
	// A watchdog reset request leaves software enable off
	AST_RESET_DROPS_SW: assert property (device_reset_req |->
		!sw_watchdog_enable)
		else $error("software enable kept through watchdog reset");
endmodule
bind windowed_watchdog_timer
	windowed_watchdog_timer_assertions #(.CNT_W(CNT_W))
	windowed_watchdog_timer_assertions_inst (.*);

/* File: bench/core_model.sv */
// Processor core model issuing clear and power-save strobes
`timescale 1ns/1ps
module core_model (
	input  wire logic clk,
	output logic      clr,
	output logic      save,
	output logic      save_idle
);
	// Strobes idle until commanded
	initial begin
		clr = 1'h0;
		save = 1'h0;
		save_idle = 1'h0;
	end
	// One-cycle clear strobe launched after an edge
	task clr_pulse;
		@(posedge clk);
		#1 clr = 1'h1;
		@(posedge clk);
		#1 clr = 1'h0;
	endtask
	// One-cycle power-save strobe, idle or sleep held beside it
	task save_pulse(input logic idle);
		@(posedge clk);
		#1 save = 1'h1;
		save_idle = idle;
		@(posedge clk);
		#1 save = 1'h0;
	endtask
endmodule

/* File: bench/tb_windowed_watchdog_timer.sv */
// Self-checking bench for the windowed watchdog timer
`timescale 1ns/1ps
module tb_windowed_watchdog_timer;
	logic clk = 0, arst_n = 0, osc = 0, cfg_load = 0, win_pres = 1;
	logic dev_rst = 0, clk_sw = 0, sw_wr = 0, sw_wd = 0, st_clr = 0;
	logic ce = 1'h1, ow = 1'h0;
	logic [7:0] cfg_in = 8'hFF, cfg_q;
	logic [1:0] win_sel = 2'h3;
	logic sw_en, to_f, sl_f, id_f, act, rst_req, wake, clr, ps, ps_idle;
	logic rst_seen = 0;
	logic [21:0] cnt;
	int err_count = 0, samples_checked = 0, cyc = 0;
	windowed_watchdog_timer windowed_watchdog_timer_inst (.clk(clk),
		.arst_n(arst_n), .clk_en(ce), .low_power_rc_osc(osc),
		.cfg_load(cfg_load), .cfg_word_in(cfg_in),
		.window_size_select(win_sel), .window_bits_present(win_pres),
		.watchdog_clear_instr(clr), .power_save_instr(ps),
		.power_save_idle(ps_idle), .other_wake(ow),
		.device_reset_in(dev_rst), .clock_switch_done(clk_sw),
		.sw_enable_wr(sw_wr), .sw_enable_wdata(sw_wd),
		.status_clear(st_clr), .config_word_one(cfg_q),
		.sw_watchdog_enable(sw_en), .timeout_status_flag(to_f),
		.sleep_status_flag(sl_f), .idle_status_flag(id_f),
		.watchdog_active(act), .device_reset_req(rst_req),
		.core_wake(wake), .watchdog_counter(cnt));
	core_model core_model_inst (.clk(clk), .clr(clr), .save(ps),
		.save_idle(ps_idle));
	always #12.5 clk = ~clk;
	// Oscillator: one tick every two clocks
	always @(posedge clk) #1 osc = ~osc;
	// Sticky record of reset requests, plus hang limit
	always @(posedge clk) begin
		cyc++;
		if (rst_req === 1'h1) rst_seen <= 1'h1;
		if (cyc == 10000) begin
			err_count++;
			close_out;
		end
	end
	task check(string n, logic [31:0] s, logic [31:0] e);
		samples_checked++;
		if (s !== e) begin
			err_count++;
			$display("mismatch %s expected %0h seen %0h", n, e, s);
		end
	endtask
	task step(int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic pulse(ref logic s);
		s = 1'h1;
		step(1);
		s = 1'h0;
	endtask
	task load(logic [7:0] v);
		cfg_in = v;
		pulse(cfg_load);
	endtask
	// Wait for wake (w=1) or reset request, bounded
	task automatic wait_ev(bit w, int lim, output int n);
		n = 0;
		while ((w ? wake : rst_req) !== 1'h1 && n < lim) begin
			step(1);
			n++;
		end
	endtask
	task wait_cnt(int v);
		for (int k = 0; k < 600 && cnt !== v; k++) step(1);
	endtask
	task t_reset;
		check("cfg", cfg_q, 8'hFF);
		check("sw_en", sw_en, 1'h0);
		check("to_f", to_f, 1'h0);
		check("active", act, 1'h1);
		$display("test reset done");
	endtask
	task automatic t_period;
		int n;
		logic [7:0] c [3] = '{8'hC0, 8'hC1, 8'hD0};
		int t [3] = '{32, 64, 128};
		for (int i = 0; i < 3; i++) begin
			load(c[i]);
			pulse(clk_sw);
			wait_ev(0, 400, n);
			check("period", n >= 2*t[i]-6 && n <= 2*t[i]+6, 1);
			check("to_f", to_f, 1'h1);
			check("no_wake", wake, 1'h0);
		end
		$display("test period done");
	endtask
	task t_sleep;
		int n;
		load(8'hC0);
		for (int i = 0; i < 2; i++) begin
			pulse(st_clr);
			core_model_inst.save_pulse(i[0]);
			wait_ev(1, 100, n);
			check("wake", wake, 1'h1);
			check("no_reset", rst_req, 1'h0);
			check("to_f", to_f, 1'h1);
			check("sleep", sl_f, !i[0]);
			check("idle", id_f, i[0]);
		end
		$display("test sleep done");
	endtask
	task t_clear;
		load(8'hC0);
		pulse(clk_sw);
		rst_seen = 0;
		repeat (10) begin
			step(40);
			core_model_inst.clr_pulse;
		end
		check("kept", rst_seen, 1'h0);
		$display("test clear done");
	endtask
	task automatic t_window;
		int n;
		logic [1:0] s [5] = '{2'h3, 2'h2, 2'h1, 2'h0, 2'h0};
		int lim [5] = '{24, 20, 16, 8, 24};
		load(8'h80);
		for (int i = 0; i < 5; i++) begin
			win_sel = s[i];
			win_pres = (i < 4);
			pulse(clk_sw);
			wait_cnt(lim[i] - 2);
			core_model_inst.clr_pulse;
			wait_ev(0, 4, n);
			check("early", rst_req, 1'h1);
			pulse(clk_sw);
			wait_cnt(lim[i] + 1);
			rst_seen = 0;
			core_model_inst.clr_pulse;
			step(4);
			check("late", rst_seen, 1'h0);
			check("restart", cnt < 4, 1);
		end
		$display("test window done");
	endtask
	task t_soft;
		load(8'h00);
		pulse(clk_sw);
		step(6);
		check("off", act, 1'h0);
		check("held", cnt, 0);
		sw_wd = 1'h1;
		pulse(sw_wr);
		step(6);
		check("on", act, 1'h1);
		wait_cnt(3);
		rst_seen = 0;
		core_model_inst.clr_pulse;
		step(4);
		check("no_window", rst_seen, 1'h0);
		pulse(dev_rst);
		step(1);
		check("sw_drop", sw_en, 1'h0);
		$display("test soft done");
	endtask
	// Clock enable freeze, outside wake, then a second reset
	task automatic t_hold;
		logic [21:0] c0;
		int n;
		load(8'hC0);
		pulse(clk_sw);
		step(10);
		c0 = cnt;
		ce = 1'h0;
		step(80);
		check("frozen", cnt, c0);
		check("frozen_rst", rst_req, 1'h0);
		ce = 1'h1;
		core_model_inst.save_pulse(1'h0);
		step(4);
		pulse(ow);
		wait_ev(0, 100, n);
		check("ow_reset", rst_req, 1'h1);
		check("ow_wake", wake, 1'h0);
		arst_n = 1'h0;
		step(2);
		arst_n = 1'h1;
		step(2);
		check("rst_cfg", cfg_q, 8'hFF);
		check("rst_to", to_f, 1'h0);
		check("rst_act", act, 1'h1);
		check("rst_cnt", cnt < 4, 1);
		$display("test hold done");
	endtask
	task close_out;
		$display("checks %0d mismatches %0d", samples_checked, err_count);
		if (err_count == 0 && samples_checked > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	initial begin
		step(4);
		arst_n = 1'h1;
		step(3);
		t_reset;
		t_period;
		t_sleep;
		t_clear;
		t_window;
		t_soft;
		t_hold;
		close_out;
	end
endmodule
